// [core/motor_cmd_regs.svh]
// Constants of the run/stop command logic
`ifndef MOTOR_CMD_REGS_SVH
`define MOTOR_CMD_REGS_SVH
`define STOP_TYPE_W        2
`define STOP_TYPE_FREEWHEEL 2'h0
`define STOP_TYPE_CONTROL  2'h1
`define STOP_TYPE_BRAKE    2'h2
`define SYNC_RESET_VAL     2'h0
`endif

// [core/motor_cmd_pkg.sv]
// Types of the run/stop command logic
package motor_cmd_pkg;
   typedef enum logic [3:0] {
      ST_IDLE    = 4'h1,
      ST_RUN     = 4'h2,
      ST_FAULT   = 4'h4,
      ST_PENDING = 4'h8
   } run_state_t;
   typedef logic [1:0] stop_type_t;
endpackage

// [core/input_sync.sv]
// Two-stage synchroniser for the logic input pins
module input_sync (
   // Clock, reset and enable
   input  wire logic core_clk,
   input  wire logic rst,
   input  wire logic clk_en,
   // Pins
   input  wire logic [1:0] pin_in,
   output logic      [1:0] pin_sync
);
`include "motor_cmd_regs.svh"
   logic [1:0] meta_q;
   logic [1:0] meta_d;
   logic [1:0] sync_q;
   logic [1:0] sync_d;

   always_comb begin
      meta_d = meta_q;
      sync_d = sync_q;
      if (clk_en) begin
         meta_d = pin_in;
         sync_d = meta_q;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         meta_q <= `SYNC_RESET_VAL;
         sync_q <= `SYNC_RESET_VAL;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign pin_sync = sync_q;
endmodule // input_sync

// [core/motor_run_stop_cmd.sv]
// Run/stop command logic of a motor soft starter
`include "motor_cmd_regs.svh"

// Operation
// [R1] Two-wire: run follows both input levels
// [R2] Two-wire: restart after power-up or reset
// [R3] Three-wire: separate run and stop inputs
// [R4] Three-wire: stop opens, motor stops
// [R5] Three-wire: run pulse held until stop
// [R6] Delta winding option setting selects inside-delta
// [R7] Delta: only freewheel stop allowed
// [R8] Delta: cascade function disabled
// [R9] Delta: preheating disabled
// [R10] Stop high and run high start
// [R11] Stop input active low, gates run
// [R12] Fault stops, clears latch, awaits reset
module motor_run_stop_cmd (
   // Clock, reset, enable
   input  wire logic                     core_clk,
   input  wire logic                     rst,
   input  wire logic                     clk_en,
   // Logic input pins
   input  wire logic                     run_pin,
   input  wire logic                     stop_n_pin,
   // Configuration
   input  wire logic                     three_wire_mode,
   input  wire logic                     delta_winding_option,
   input  wire motor_cmd_pkg::stop_type_t stop_type_sel,
   input  wire logic                     cascade_en,
   input  wire logic                     preheat_en,
   // Fault handling
   input  wire logic                     fault_detect,
   input  wire logic                     fault_reset,
   // Outputs
   output logic                          motor_run,
   output logic                          run_latched,
   output logic                          fault_active,
   output motor_cmd_pkg::stop_type_t     stop_type_eff,
   output logic                          stop_sel_refused,
   output logic                          cascade_active,
   output logic                          preheat_active
);
   import motor_cmd_pkg::*;

   logic [1:0] pins_sync;
   logic       run_s;
   logic       stop_n_s;

   input_sync u_sync (
      .core_clk (core_clk),
      .rst      (rst),
      .clk_en   (clk_en),
      .pin_in   ({run_pin, stop_n_pin}),
      .pin_sync (pins_sync)
   );
   assign run_s    = pins_sync[1];
   assign stop_n_s = pins_sync[0];

   // Command state
   run_state_t state_q;
   run_state_t state_d;
   logic       latch_q;
   logic       latch_d;
   logic       run_req;

   // Three-wire run request held in latch
   always_comb begin
      latch_d = latch_q;
      if (clk_en) begin
         // Only three-wire stores a pulse; a stale request would start on mode change
         if (!three_wire_mode || !stop_n_s || fault_detect || state_q == ST_FAULT) begin
            latch_d = 1'h0; // R3 R4 R5 R12
         end else if (run_s) begin
            latch_d = 1'b1; // R5
         end
      end
   end

   always_comb begin
      if (three_wire_mode) begin
         run_req = stop_n_s && (latch_q || run_s); // R3 R11
      end else begin
         run_req = stop_n_s && run_s; // R1 R10 R11
      end
   end

   always_comb begin
      state_d = state_q;
      if (clk_en) begin
         unique case (state_q)
            ST_IDLE: begin
               if (fault_detect) state_d = ST_FAULT; // R12
               else if (run_req) state_d = ST_RUN;
            end
            ST_RUN: begin
               if (fault_detect) state_d = ST_FAULT; // R12
               else if (!run_req) state_d = ST_IDLE; // R4 R10
            end
            ST_FAULT: begin
               if (fault_reset && !fault_detect) state_d = ST_PENDING;
            end
            ST_PENDING: begin
               // Both modes restart on held run; a three-wire run stored before the fault is not kept
               if (fault_detect) state_d = ST_FAULT;
               else if (run_req) state_d = ST_RUN; // R2
               else state_d = ST_IDLE;
            end
            default: state_d = ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         state_q <= ST_IDLE;
         latch_q <= 1'b0;
      end else begin
         state_q <= state_d;
         latch_q <= latch_d;
      end
   end

   // Delta winding restrictions, registered
   stop_type_t stop_q;
   stop_type_t stop_d;
   logic       refuse_q;
   logic       refuse_d;
   logic       casc_q;
   logic       casc_d;
   logic       heat_q;
   logic       heat_d;

   always_comb begin
      stop_d   = stop_q;
      refuse_d = refuse_q;
      casc_d   = casc_q;
      heat_d   = heat_q;
      if (clk_en) begin
         if (delta_winding_option) begin // R6
            stop_d   = `STOP_TYPE_FREEWHEEL; // R7
            refuse_d = (stop_type_sel != `STOP_TYPE_FREEWHEEL); // R7
         end else begin
            stop_d   = stop_type_sel;
            refuse_d = 1'b0;
         end
         casc_d = cascade_en && !delta_winding_option; // R8
         heat_d = preheat_en && !delta_winding_option &&
                  state_d != ST_RUN && state_d != ST_FAULT; // R9
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         stop_q   <= `STOP_TYPE_FREEWHEEL;
         refuse_q <= 1'b0;
         casc_q   <= 1'b0;
         heat_q   <= 1'b0;
      end else begin
         stop_q   <= stop_d;
         refuse_q <= refuse_d;
         casc_q   <= casc_d;
         heat_q   <= heat_d;
      end
   end

   assign motor_run        = (state_q == ST_RUN);
   assign run_latched      = latch_q;
   assign fault_active     = (state_q == ST_FAULT);
   assign stop_type_eff    = stop_q;
   assign stop_sel_refused = refuse_q;
   assign cascade_active   = casc_q;
   assign preheat_active   = heat_q;

   // Checks
   chk_stop_forces_idle: assert property (@(posedge core_clk) disable iff (rst) // R4
      (clk_en && !stop_n_s && state_q == ST_RUN) |=> !motor_run)
      else $error("Motor kept running with stop open");
   chk_stop_clears_latch: assert property (@(posedge core_clk) disable iff (rst) // R5
      (clk_en && !stop_n_s) |=> !run_latched)
      else $error("Run latch survived open stop");
   chk_latch_holds: assert property (@(posedge core_clk) disable iff (rst) // R5
      (clk_en && three_wire_mode && run_s && stop_n_s && !fault_detect && state_q != ST_FAULT)
      |=> run_latched)
      else $error("Run pulse not captured");
   chk_two_wire_start: assert property (@(posedge core_clk) disable iff (rst) // R1
      (clk_en && !three_wire_mode && state_q == ST_IDLE && run_s && stop_n_s
       && !fault_detect) |=> motor_run)
      else $error("Two-wire run level did not start motor");
   chk_delta_freewheel: assert property (@(posedge core_clk) disable iff (rst) // R7
      (clk_en && delta_winding_option) |=> stop_type_eff == `STOP_TYPE_FREEWHEEL)
      else $error("Non-freewheel stop with delta option");
   chk_delta_refuse: assert property (@(posedge core_clk) disable iff (rst) // R7
      (clk_en && delta_winding_option && stop_type_sel != `STOP_TYPE_FREEWHEEL)
      |=> stop_sel_refused)
      else $error("Stop selection not refused under delta option");
   chk_delta_cascade: assert property (@(posedge core_clk) disable iff (rst) // R8
      (clk_en && delta_winding_option) |=> !cascade_active)
      else $error("Cascade active with delta option");
   chk_delta_preheat: assert property (@(posedge core_clk) disable iff (rst) // R9
      (clk_en && delta_winding_option) |=> !preheat_active)
      else $error("Preheat active with delta option");
   chk_fault_blocks: assert property (@(posedge core_clk) disable iff (rst) // R12
      (clk_en && fault_detect) |=> (!motor_run && !run_latched) [*2])
      else $error("Fault did not stop motor");
   chk_fault_restart: assert property (@(posedge core_clk) disable iff (rst) // R2
      (clk_en && state_q == ST_PENDING && !three_wire_mode && run_s && stop_n_s
       && !fault_detect) |=> motor_run)
      else $error("No restart after fault reset with run held");
   chk_latch_two_wire: assert property (@(posedge core_clk) disable iff (rst) // R3
      (clk_en && !three_wire_mode) |=> !run_latched)
      else $error("Run latch set in two-wire mode");
   chk_three_wire_hold: assert property (@(posedge core_clk) disable iff (rst) // R5
      (clk_en && three_wire_mode && motor_run && run_latched && stop_n_s && !fault_detect)
      |=> motor_run)
      else $error("Stored run request did not keep motor running");
   chk_delta_off_pass: assert property (@(posedge core_clk) disable iff (rst) // R6
      (clk_en && !delta_winding_option)
      |=> (stop_type_eff == $past(stop_type_sel) && !stop_sel_refused))
      else $error("Stop selection not passed through without delta option");
   chk_preheat_idle: assert property (@(posedge core_clk) disable iff (rst) // R9
      (motor_run || fault_active) |-> !preheat_active)
      else $error("Preheat active while running or faulted");
   chk_fault_entry: assert property (@(posedge core_clk) disable iff (rst) // R12
      (clk_en && fault_detect) |=> fault_active)
      else $error("Fault state not entered");
   chk_fault_holds: assert property (@(posedge core_clk) disable iff (rst) // R12
      (clk_en && fault_active && !fault_reset) |=> (fault_active && !motor_run))
      else $error("Fault state left without a fault reset");
endmodule // motor_run_stop_cmd

// [tb/operator_panel.sv]
// Pushbutton model driving the run and stop logic inputs
module operator_panel (
   // Clock
   input  wire logic core_clk,
   // Commands from the bench
   input  wire logic want_run,
   input  wire logic want_stop,
   // Logic input pins
   output logic      run_pin,
   output logic      stop_n_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      run_pin    = 1'b0;
      stop_n_pin = 1'b1;
   end
   // Contacts move just after the edge
   always @(posedge core_clk) begin
      run_pin    <= #1 want_run;
      stop_n_pin <= #1 !want_stop;
   end
endmodule // operator_panel

// [tb/motor_run_stop_cmd_test.sv]
// Self-checking bench of the run/stop command logic
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin n_errors++; \
   $display("unexpected at %0t: outputs %h, wanted %h", $time, got, exp); end end
module motor_run_stop_cmd_test;
   timeunit 1ns;
   timeprecision 1ps;
   import motor_cmd_pkg::*;
   typedef struct {logic [7:0] mask; logic [7:0] val;} note_t;
   logic core_clk, rst, want_run, want_stop, run_pin, stop_n_pin, three_wire_mode;
   logic delta_winding_option, cascade_en, preheat_en, fault_detect, fault_reset;
   logic motor_run, run_latched, fault_active, stop_sel_refused, cascade_active;
   logic preheat_active, clk_en;
   logic [7:0] outs;
   stop_type_t stop_type_sel, stop_type_eff;
   note_t note_q[$];
   note_t n;
   int n_errors = 0, checks = 0, cyc = 0;
   logic [31:0] seed = 32'h148a;
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   operator_panel panel (.core_clk(core_clk), .want_run(want_run), .want_stop(want_stop),
      .run_pin(run_pin), .stop_n_pin(stop_n_pin));
   motor_run_stop_cmd dut (.core_clk(core_clk), .rst(rst), .clk_en(clk_en),
      .run_pin(run_pin), .stop_n_pin(stop_n_pin), .three_wire_mode(three_wire_mode),
      .delta_winding_option(delta_winding_option), .stop_type_sel(stop_type_sel),
      .cascade_en(cascade_en), .preheat_en(preheat_en), .fault_detect(fault_detect),
      .fault_reset(fault_reset), .motor_run(motor_run), .run_latched(run_latched),
      .fault_active(fault_active), .stop_type_eff(stop_type_eff),
      .stop_sel_refused(stop_sel_refused), .cascade_active(cascade_active),
      .preheat_active(preheat_active));
   assign outs = {motor_run, run_latched, fault_active, stop_type_eff, stop_sel_refused,
      cascade_active, preheat_active};
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   task automatic results();
      $display("comparisons %0d, mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge core_clk);
      #1;
   endtask
   task automatic go(input logic r, input logic s, input int k);
      want_run  = r;
      want_stop = s;
      tick(k);
   endtask
   task automatic note(input logic [7:0] m, input logic [7:0] v);
      note_q.push_back('{m, v});
      tick(1);
   endtask
   // Watcher: compares the oldest note with the outputs
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc > 1000) begin
         n_errors++;
         results();
      end else if (note_q.size() > 0) begin
         n = note_q.pop_front();
         `CHK(outs & n.mask, n.val)
      end
   end
   initial begin
      {want_stop, three_wire_mode, delta_winding_option, fault_detect} = '0;
      {fault_reset, cascade_en, preheat_en} = '0;
      want_run = 1'b1;
      clk_en   = 1'b1;
      stop_type_sel = 2'h0;
      rst = 1'b1;
      tick(8);
      rst = 1'b0;
      tick(6);
      note(8'ha0, 8'h80);
      go(1, 1, 6);
      note(8'h80, 8'h00);
      go(1, 0, 6);
      note(8'h80, 8'h80);
      fault_detect = 1'b1;
      tick(2);
      note(8'he0, 8'h20);
      fault_detect = 1'b0;
      tick(4);
      note(8'ha0, 8'h20);
      fault_reset = 1'b1;
      tick(1);
      fault_reset = 1'b0;
      tick(4);
      note(8'ha0, 8'h80);
      $display("two-wire and fault test done");
      three_wire_mode = 1'b1;
      go(0, 1, 6);
      go(1, 0, 1);
      go(0, 0, 6);
      note(8'hc0, 8'hc0);
      go(0, 1, 6);
      note(8'hc0, 8'h00);
      go(1, 1, 6);
      note(8'hc0, 8'h00);
      $display("three-wire test done");
      three_wire_mode = 1'b0;
      go(0, 0, 1);
      {cascade_en, preheat_en} = 2'h3;
      for (int i = 0; i < 9; i++) begin
         seed = lfsr(seed);
         stop_type_sel = (i < 3) ? i[1:0] : ((seed[1:0] == 2'h3) ? 2'h1 : seed[1:0]);
         delta_winding_option = 1'b1;
         tick(3);
         note(8'h1f, {5'h0, stop_type_sel != 2'h0, 2'h0});
         delta_winding_option = 1'b0;
         tick(3);
         note(8'h1f, {3'h0, stop_type_sel, 3'h3});
      end
      $display("delta winding test done");
      go(1, 0, 6);
      note(8'h81, 8'h80);
      clk_en = 1'b0;
      go(1, 1, 6);
      note(8'h80, 8'h80);
      clk_en = 1'b1;
      tick(5);
      note(8'h81, 8'h01);
      go(1, 0, 6);
      rst = 1'b1;
      tick(2);
      note(8'hff, 8'h00);
      rst = 1'b0;
      tick(5);
      note(8'h83, 8'h82);
      $display("enable and reset test done");
      tick(2);
      results();
   end
endmodule // motor_run_stop_cmd_test
